// ==== pkg/dmaseq_regs.vh ====
// constants of the dma cycle sequencer
`ifndef DMASEQ_REGS_VH
`define DMASEQ_REGS_VH
`define DMASEQ_ST_IDLE 4'h0
`define DMASEQ_ST_PROG 4'h1
`define DMASEQ_ST_HOLD 4'h2
`define DMASEQ_ST_S1 4'h3
`define DMASEQ_ST_S2 4'h4
`define DMASEQ_ST_S3 4'h5
`define DMASEQ_ST_S4 4'h6
`define DMASEQ_ST_WAIT 4'h7
`define DMASEQ_ST_S11 4'h8
`define DMASEQ_ST_S12 4'h9
`define DMASEQ_ST_S13 4'hA
`define DMASEQ_ST_S14 4'hB
`define DMASEQ_ST_S21 4'hC
`define DMASEQ_ST_S22 4'hD
`define DMASEQ_ST_S23 4'hE
`define DMASEQ_ST_S24 4'hF
`define DMASEQ_XFER_VERIFY 2'h0
`define DMASEQ_XFER_WRITE 2'h1
`define DMASEQ_XFER_READ 2'h2
`define DMASEQ_COUNT_WRAP 16'hFFFF
`define DMASEQ_COUNT_ZERO 16'h0000
`define DMASEQ_ADDR_STEP 16'h0001
`endif

// ==== hw/dmaseq_sync2.v ====
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module dmaseq_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk_sys,
  input wire nrst,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
    end
  end
  assign syncOut = sync_reg;
endmodule
`default_nettype wire

// ==== hw/dmaseq_counter.v ====
// per-channel current address and word count
`timescale 1ns/1ps
`default_nettype none
`include "dmaseq_regs.vh"
module dmaseq_counter (
  input wire clk_sys,
  input wire nrst,
  input wire load,
  input wire [15:0] loadAddr,
  input wire [15:0] loadCount,
  input wire step,
  input wire holdAddr,
  input wire addrDown,
  output wire [15:0] curAddr,
  output wire [15:0] curCount,
  output wire countWraps
);
  reg [15:0] addr_reg;
  reg [15:0] count_reg;
  assign curAddr = addr_reg;
  assign curCount = count_reg;
  assign countWraps = (count_reg == `DMASEQ_COUNT_ZERO);
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr_reg <= 16'h0000;
      count_reg <= 16'h0000;
    end else if (load) begin
      addr_reg <= loadAddr;
      count_reg <= loadCount;
    end else if (step) begin
      count_reg <= count_reg - `DMASEQ_ADDR_STEP;
      if (!holdAddr) begin
        if (addrDown) begin
          addr_reg <= addr_reg - `DMASEQ_ADDR_STEP;
        end else begin
          addr_reg <= addr_reg + `DMASEQ_ADDR_STEP;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/dma_cycle_sequencer.v ====
// bus-cycle sequencer and external signalling of a four-channel dma engine
// Behaviour
// - pulse process end low when active word count wraps from zero to ones.
// - external low on process end terminates transfer like final count.
// - on any process end, stop transfer and clear channel pending request.
// - cascade channels get no process end termination.
// - low nibble is register select when idle, address 0-3 when active.
// - mid nibble drives address 4-7 only in active cycles.
// - repeat hold wait state while grant low; it occurs at least twice.
// - per-channel acknowledge, active low at reset, polarity programmable.
// - no acknowledge during memory-to-memory transfers.
// - address out valid high while bus outputs are valid.
// - pulse upper address strobe to latch upper address byte.
// - memory read and write strobes per transfer type, undriven when idle.
// - each state begins on a rising edge and lasts one clock.
// - idle cycle samples requests and chip select every clock.
// - idle, grant low, chip select low enters programming state.
// - valid unmasked or software request raises hold request, starts active.
// - four states for io-memory, four read plus four write for mem-mem.
// - ready low inserts wait states.
// - final state decrements count, steps address up or down.
// - reset enters idle cycle.
`timescale 1ns/1ps
`default_nettype none
`include "dmaseq_regs.vh"
module dma_cycle_sequencer #(
  parameter NCH = 4
) (
  input wire clk_sys,
  input wire nrst,
  input wire [NCH-1:0] channel_request,
  input wire [NCH-1:0] softRequest,
  input wire [NCH-1:0] channelMask,
  input wire [NCH-1:0] cascadeMode,
  input wire [NCH-1:0] addrDown,
  input wire [2*NCH-1:0] xferType,
  input wire [NCH-1:0] channelLoad,
  input wire [16*NCH-1:0] loadAddr,
  input wire [16*NCH-1:0] loadCount,
  input wire requestActiveLow,
  input wire ackActiveHigh,
  input wire memToMem,
  input wire holdSrcAddr,
  input wire chipSelectN,
  input wire bus_hold_grant,
  input wire ready,
  input wire process_end_n_in,
  output reg process_end_n_out,
  output reg process_end_n_oe,
  output reg bus_hold_request,
  output reg [NCH-1:0] channel_acknowledge,
  output reg address_out_valid,
  output reg upper_address_strobe,
  input wire [3:0] low_address_nibble_in,
  output reg [3:0] low_address_nibble_out,
  output reg low_address_nibble_oe,
  output reg [3:0] mid_address_nibble_out,
  output reg mid_address_nibble_oe,
  output reg [7:0] dataOut,
  output reg dataOe,
  output reg mem_read_n,
  output reg mem_write_n,
  output reg memStrobeOe,
  output reg io_read_n_out,
  output reg io_write_n_out,
  output reg ioStrobeOe,
  output reg [3:0] regSelect,
  output reg programming,
  output reg [NCH-1:0] requestPending,
  output reg final_count_reached,
  output reg wait_state
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  wire [NCH-1:0] reqSync;
  wire grantSync;
  wire csSyncN;
  wire readySync;
  wire eopSyncN;
  // reset levels: grant low, select, ready and process end high
  dmaseq_sync2 #(.WIDTH(NCH+4), .INIT({{NCH{1'b0}}, 4'h7})) uSync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .asyncIn({channel_request, bus_hold_grant, chipSelectN, ready,
      process_end_n_in}),
    .syncOut({reqSync, grantSync, csSyncN, readySync, eopSyncN})
  );
  wire [NCH-1:0] hwReq = requestActiveLow ? ~reqSync : reqSync;
  ////////////////////////////////////////////////////////////////////////////
  // per-channel counters
  reg [NCH-1:0] step;
  wire [16*NCH-1:0] curAddr;
  wire [NCH-1:0] wraps;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gCh
      dmaseq_counter uCnt (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .load(channelLoad[g]),
        .loadAddr(loadAddr[16*g+15:16*g]),
        .loadCount(loadCount[16*g+15:16*g]),
        .step(step[g]),
        .holdAddr(holdSrcAddr && memToMem && (g == 0)),
        .addrDown(addrDown[g]),
        .curAddr(curAddr[16*g+15:16*g]),
        .curCount(),
        .countWraps(wraps[g])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // state and channel selection
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [1:0] chan_reg;
  reg [1:0] chan_next;
  reg [NCH-1:0] swPend_reg;
  wire [NCH-1:0] valid = (hwReq & ~channelMask) | swPend_reg | softRequest;
  reg [1:0] pick;
  integer i;
  always @* begin
    pick = 2'h0;
    for (i = NCH - 1; i >= 0; i = i - 1) begin
      if (valid[i]) begin
        pick = i[1:0];
      end
    end
  end
  wire [1:0] xt = xferType[2*chan_reg+:2];
  wire isVerify = (xt == `DMASEQ_XFER_VERIFY);
  wire useReady = !isVerify || memToMem;
  // cascade channels ignore an external process end
  wire extEnd = !eopSyncN && !cascadeMode[chan_reg];
  wire cntWrap = memToMem ? wraps[1] : wraps[chan_reg];
  wire inActive = (state_reg >= `DMASEQ_ST_S1);
  reg [3:0] waitRet_reg;
  // outputs mostly registered on the edge that closes each state; hold request, programming and wait on the edge that opens it
  always @* begin
    state_next = state_reg;
    chan_next = chan_reg;
    case (state_reg)
      `DMASEQ_ST_IDLE, `DMASEQ_ST_PROG: begin
        // a grant left over from the last cycle must drop first, or the
        // hold wait state would be skipped
        if (|valid && !grantSync) begin
          state_next = `DMASEQ_ST_HOLD;
          chan_next = memToMem ? 2'h0 : pick;
        end else if (!grantSync && !csSyncN) begin
          state_next = `DMASEQ_ST_PROG;
        end else begin
          state_next = `DMASEQ_ST_IDLE;
        end
      end
      `DMASEQ_ST_HOLD: begin
        if (grantSync) begin
          state_next = memToMem ? `DMASEQ_ST_S11 : `DMASEQ_ST_S1;
        end
      end
      `DMASEQ_ST_S1: state_next = `DMASEQ_ST_S2;
      `DMASEQ_ST_S2: state_next = `DMASEQ_ST_S3;
      `DMASEQ_ST_S3: state_next = `DMASEQ_ST_S4;
      `DMASEQ_ST_S11: state_next = `DMASEQ_ST_S12;
      `DMASEQ_ST_S12: state_next = `DMASEQ_ST_S13;
      `DMASEQ_ST_S13: state_next = `DMASEQ_ST_S14;
      `DMASEQ_ST_S14: state_next = `DMASEQ_ST_S21;
      `DMASEQ_ST_S21: state_next = `DMASEQ_ST_S22;
      `DMASEQ_ST_S22: state_next = `DMASEQ_ST_S23;
      `DMASEQ_ST_S23: state_next = `DMASEQ_ST_S24;
      `DMASEQ_ST_WAIT: begin
        // resume at the state after the one that was stretched
        if (readySync) begin
          state_next = waitRet_reg + 4'h1;
        end
      end
      default: state_next = `DMASEQ_ST_IDLE;
    endcase
    if ((state_reg == `DMASEQ_ST_S3 || state_reg == `DMASEQ_ST_S13 ||
        state_reg == `DMASEQ_ST_S23) && useReady && !readySync) begin
      state_next = `DMASEQ_ST_WAIT;
    end
    if (state_reg == `DMASEQ_ST_S4 || state_reg == `DMASEQ_ST_S24 ||
        (inActive && extEnd)) begin
      state_next = `DMASEQ_ST_IDLE;
    end
  end
  wire lastState = (state_reg == `DMASEQ_ST_S4) ||
    (state_reg == `DMASEQ_ST_S24);
  wire endNow = inActive && (extEnd || (lastState && cntWrap));
  always @* begin
    step = {NCH{1'b0}};
    if (state_reg == `DMASEQ_ST_S4) begin
      step[chan_reg] = 1'b1;
    end else if (state_reg == `DMASEQ_ST_S24) begin
      step[0] = 1'b1;
      step[1] = 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // sequencing registers
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= `DMASEQ_ST_IDLE;
      chan_reg <= 2'h0;
      swPend_reg <= {NCH{1'b0}};
      waitRet_reg <= `DMASEQ_ST_S3;
    end else begin
      state_reg <= state_next;
      chan_reg <= chan_next;
      if (state_next == `DMASEQ_ST_WAIT && state_reg != `DMASEQ_ST_WAIT) begin
        waitRet_reg <= state_reg;
      end
      // set wins over the clear from process end
      swPend_reg <= (swPend_reg & ~(endNow ? (4'h1 << chan_reg) : 4'h0)) |
        softRequest;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pin outputs
  // memory-to-memory wait states belong to the phase they stretch, so the
  // strobe and the address of that phase stay in place
  wire readPhase = (state_reg >= `DMASEQ_ST_S11 &&
    state_reg <= `DMASEQ_ST_S14) || (state_reg == `DMASEQ_ST_WAIT &&
    waitRet_reg == `DMASEQ_ST_S13);
  wire writePhase = (state_reg >= `DMASEQ_ST_S21) ||
    (state_reg == `DMASEQ_ST_WAIT && waitRet_reg == `DMASEQ_ST_S23);
  wire [15:0] addrSel = writePhase ? curAddr[31:16] :
    curAddr[16*chan_reg+:16];
  wire ioStrobeState = (state_reg == `DMASEQ_ST_S2) ||
    (state_reg == `DMASEQ_ST_S3) || (state_reg == `DMASEQ_ST_WAIT &&
    !memToMem);
  wire wrStrobeState = (state_reg == `DMASEQ_ST_S3) ||
    (state_reg == `DMASEQ_ST_WAIT && !memToMem);
  wire [NCH-1:0] ackOn = (inActive && !memToMem) ?
    (4'h1 << chan_reg) : 4'h0;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      process_end_n_out <= 1'b1;
      process_end_n_oe <= 1'b0;
      bus_hold_request <= 1'b0;
      channel_acknowledge <= {NCH{1'b1}};
      address_out_valid <= 1'b0;
      upper_address_strobe <= 1'b0;
      low_address_nibble_out <= 4'h0;
      low_address_nibble_oe <= 1'b0;
      mid_address_nibble_out <= 4'h0;
      mid_address_nibble_oe <= 1'b0;
      dataOut <= 8'h00;
      dataOe <= 1'b0;
      mem_read_n <= 1'b1;
      mem_write_n <= 1'b1;
      memStrobeOe <= 1'b0;
      io_read_n_out <= 1'b1;
      io_write_n_out <= 1'b1;
      ioStrobeOe <= 1'b0;
      regSelect <= 4'h0;
      programming <= 1'b0;
      requestPending <= {NCH{1'b0}};
      final_count_reached <= 1'b0;
      wait_state <= 1'b0;
    end else begin
      process_end_n_out <= 1'b0;
      process_end_n_oe <= lastState && cntWrap &&
        !cascadeMode[chan_reg];
      final_count_reached <= endNow;
      // hold request falls as the cycle returns to idle
      bus_hold_request <= (state_next != `DMASEQ_ST_IDLE) &&
        (state_next != `DMASEQ_ST_PROG);
      channel_acknowledge <= ackActiveHigh ? ackOn : ~ackOn;
      address_out_valid <= inActive;
      // strobe with the upper byte on the data pins, inside the valid window
      upper_address_strobe <= (state_reg == `DMASEQ_ST_S1) ||
        (state_reg == `DMASEQ_ST_S11) || (state_reg == `DMASEQ_ST_S21);
      low_address_nibble_out <= addrSel[3:0];
      low_address_nibble_oe <= inActive;
      mid_address_nibble_out <= addrSel[7:4];
      mid_address_nibble_oe <= inActive;
      dataOut <= addrSel[15:8];
      dataOe <= (state_reg == `DMASEQ_ST_S1) || (state_reg == `DMASEQ_ST_S11)
        || (state_reg == `DMASEQ_ST_S21);
      mem_read_n <= !((!memToMem && xt == `DMASEQ_XFER_READ &&
        ioStrobeState) || (readPhase && state_reg != `DMASEQ_ST_S11 &&
        state_reg != `DMASEQ_ST_S14));
      mem_write_n <= !((!memToMem && xt == `DMASEQ_XFER_WRITE &&
        wrStrobeState) || (writePhase && state_reg != `DMASEQ_ST_S21 &&
        state_reg != `DMASEQ_ST_S24));
      memStrobeOe <= inActive;
      io_read_n_out <= !(!memToMem && xt == `DMASEQ_XFER_WRITE &&
        ioStrobeState);
      io_write_n_out <= !(!memToMem && xt == `DMASEQ_XFER_READ &&
        wrStrobeState);
      ioStrobeOe <= inActive && !memToMem;
      regSelect <= low_address_nibble_in;
      programming <= (state_next == `DMASEQ_ST_PROG);
      requestPending <= valid & ~((endNow ? (4'h1 << chan_reg) : 4'h0) &
        ~softRequest);
      wait_state <= (state_next == `DMASEQ_ST_WAIT);
    end
  end
endmodule
`default_nettype wire

// ==== tb/dmaseq_chk.sv ====
// concurrent checks on the ports of the dma cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module dmaseq_chk #(
  parameter NCH = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ackActiveHigh,
  input wire logic memToMem,
  input wire logic [NCH-1:0] channel_acknowledge,
  input wire logic bus_hold_request,
  input wire logic address_out_valid,
  input wire logic upper_address_strobe,
  input wire logic low_address_nibble_oe,
  input wire logic mid_address_nibble_oe,
  input wire logic mem_read_n,
  input wire logic mem_write_n,
  input wire logic memStrobeOe,
  input wire logic process_end_n_oe,
  input wire logic process_end_n_out,
  input wire logic programming
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////
  ack_mem_mem_a: assert property (memToMem && $past(memToMem) &&
    $stable(ackActiveHigh) |-> channel_acknowledge == {NCH{~ackActiveHigh}})
    else $error("acknowledge active in memory to memory transfer");
  ack_idle_a: assert property (!bus_hold_request &&
    !$past(bus_hold_request) && $stable(ackActiveHigh)
    |-> channel_acknowledge == {NCH{~ackActiveHigh}})
    else $error("acknowledge active outside an active cycle");
  eop_pulse_a: assert property (process_end_n_oe |=> !process_end_n_oe)
    else $error("process end pulse longer than one clock");
  eop_low_a: assert property (process_end_n_oe |-> !process_end_n_out)
    else $error("process end driven high");
  strobe_pulse_a: assert property (upper_address_strobe
    |=> !upper_address_strobe) else $error("address strobe too long");
  hold_wait_a: assert property ($rose(bus_hold_request)
    |-> !address_out_valid [*3]) else $error("hold wait state too short");
  mid_valid_a: assert property (mid_address_nibble_oe
    |-> address_out_valid) else $error("mid nibble driven while idle");
  low_valid_a: assert property (low_address_nibble_oe
    |-> address_out_valid) else $error("low nibble driven while idle");
  mem_strobe_a: assert property (!(mem_read_n && mem_write_n)
    |-> memStrobeOe) else $error("memory strobe active but undriven");
  prog_idle_a: assert property (programming
    |-> !address_out_valid) else $error("programming during active cycle");
  strobe_valid_a: assert property (upper_address_strobe
    |-> address_out_valid) else $error("address strobe while invalid");
endmodule
bind dma_cycle_sequencer dmaseq_chk #(.NCH(NCH)) chk (.clk_sys(clk_sys),
  .nrst(nrst), .ackActiveHigh(ackActiveHigh), .memToMem(memToMem),
  .channel_acknowledge(channel_acknowledge),
  .bus_hold_request(bus_hold_request), .address_out_valid(address_out_valid),
  .upper_address_strobe(upper_address_strobe),
  .low_address_nibble_oe(low_address_nibble_oe),
  .mid_address_nibble_oe(mid_address_nibble_oe), .mem_read_n(mem_read_n),
  .mem_write_n(mem_write_n), .memStrobeOe(memStrobeOe),
  .process_end_n_oe(process_end_n_oe),
  .process_end_n_out(process_end_n_out), .programming(programming));
`default_nettype wire

// ==== tb/dmaseq_host_model.sv ====
// cpu hold grant and peripheral request model
`timescale 1ns/1ps
`default_nettype none
module dmaseq_host_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic bus_hold_request,
  input wire logic [3:0] ackActive,
  input wire logic [3:0] wantReq,
  output logic bus_hold_grant,
  output logic [3:0] channel_request
);
  logic [1:0] lag_reg;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lag_reg <= 2'h0;
      bus_hold_grant <= 1'b0;
      channel_request <= 4'h0;
    end else begin
      // grant three clocks after the hold request, dropped one clock after it
      lag_reg <= {lag_reg[0], bus_hold_request};
      bus_hold_grant <= lag_reg[1] & bus_hold_request;
      channel_request <= (channel_request | wantReq) & ~ackActive;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench of the dma cycle sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dmaseq_regs.vh"
module tb_top;
  logic clk_sys = 1'b0, nrst = 1'b0;
  logic [3:0] softRequest = 4'h0, channelMask = 4'h0, cascadeMode = 4'h0;
  logic [3:0] addrDown = 4'h0, channelLoad = 4'h0, wantReq = 4'h0;
  logic [7:0] xferType = 8'h00;
  logic [63:0] loadAddr = 64'h0, loadCount = 64'h0;
  logic ackActiveHigh = 1'b0, memToMem = 1'b0, chipSelectN = 1'b1;
  logic ready = 1'b1, slow = 1'b0, extEop = 1'b0, eopDrive = 1'b0;
  logic [3:0] lowNib = 4'h0;
  wire grant, hold, aov, stb, eopOut, eopOe, memRd, memWr, memOe, ioRd, ioWr;
  wire ioOe, prog, tc, waitSt;
  wire [3:0] chReq, ack, regSel, pend, ackAct;
  wire [3:0] lowOut, midOut;
  wire [7:0] dOut;
  wire lowOe, midOe, dOe;
  logic [15:0] addrSeen = 16'h0000;
  integer eopT = 0;
  wire eopLine = ~(eopOe | eopDrive);
  integer n_mismatch = 0, cmp_count = 0, i;
  integer nRd, nRdFall, nWr, nIoR, nIoW, nAck, nStb, nEop, nWait, nTc;
  logic rdPrev;
  assign ackAct = ackActiveHigh ? ack : ~ack;
  always #20 clk_sys = ~clk_sys;
  dmaseq_host_model host (.clk_sys(clk_sys), .nrst(nrst),
    .bus_hold_request(hold), .ackActive(ackAct), .wantReq(wantReq),
    .bus_hold_grant(grant), .channel_request(chReq));
  dma_cycle_sequencer #(.NCH(4)) DUT (.clk_sys(clk_sys), .nrst(nrst),
    .channel_request(chReq), .softRequest(softRequest),
    .channelMask(channelMask), .cascadeMode(cascadeMode), .addrDown(addrDown),
    .xferType(xferType), .channelLoad(channelLoad), .loadAddr(loadAddr),
    .loadCount(loadCount), .requestActiveLow(1'b0),
    .ackActiveHigh(ackActiveHigh), .memToMem(memToMem), .holdSrcAddr(1'b0),
    .chipSelectN(chipSelectN), .bus_hold_grant(grant), .ready(ready),
    .process_end_n_in(eopLine), .process_end_n_out(eopOut),
    .process_end_n_oe(eopOe), .bus_hold_request(hold),
    .channel_acknowledge(ack), .address_out_valid(aov),
    .upper_address_strobe(stb), .low_address_nibble_in(lowNib),
    .low_address_nibble_out(lowOut), .low_address_nibble_oe(lowOe),
    .mid_address_nibble_out(midOut), .mid_address_nibble_oe(midOe),
    .dataOut(dOut), .dataOe(dOe), .mem_read_n(memRd), .mem_write_n(memWr),
    .memStrobeOe(memOe),
    .io_read_n_out(ioRd), .io_write_n_out(ioWr), .ioStrobeOe(ioOe),
    .regSelect(regSel), .programming(prog), .requestPending(pend),
    .final_count_reached(tc), .wait_state(waitSt));
  ////////////////////////////////////////////////////////////////////////
  // activity counters, slow ready and external process end
  always @(posedge clk_sys) begin
    if (memOe && !memRd) nRd = nRd + 1;
    if (memOe && !memRd && rdPrev) nRdFall = nRdFall + 1;
    rdPrev = !(memOe && !memRd);
    if (memOe && !memWr) nWr = nWr + 1;
    if (ioOe && !ioRd) nIoR = nIoR + 1;
    if (ioOe && !ioWr) nIoW = nIoW + 1;
    if (|ackAct) nAck = nAck + 1;
    if (stb) nStb = nStb + 1;
    if (eopOe) nEop = nEop + 1;
    if (waitSt) nWait = nWait + 1;
    ready <= !(slow && nWait < 3);
    if (tc) nTc = nTc + 1;
    if (stb && dOe && lowOe && midOe && aov)
      addrSeen = {dOut, midOut, lowOut};
    // far end holds process end low from the first valid cycle to the end
    if (extEop && aov && eopT == 0) eopT = 1;
    if (tc && eopT == 1) eopT = 2;
    eopDrive <= eopT == 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task cmp_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task load(input integer ch, input logic [15:0] cnt);
    @(posedge clk_sys);
    loadAddr[16*ch +: 16] <= 16'h12F0;
    loadCount[16*ch +: 16] <= cnt;
    channelLoad[ch] <= 1'b1;
    @(posedge clk_sys);
    channelLoad <= 4'h0;
  endtask
  // start by soft or pin request, then wait for the run to finish
  task run(input integer ch, input logic useSoft);
    nRd = 0; nRdFall = 0; nWr = 0; nIoR = 0; nIoW = 0; nAck = 0;
    nStb = 0; nEop = 0; nWait = 0; eopT = 0; nTc = 0; rdPrev = 1'b1;
    @(posedge clk_sys);
    if (useSoft) softRequest[ch] <= 1'b1;
    else wantReq[ch] <= 1'b1;
    @(posedge clk_sys);
    softRequest <= 4'h0;
    wantReq <= 4'h0;
    for (i = 0; i < 50 && hold !== 1'b1; i = i + 1) @(posedge clk_sys);
    for (i = 0; i < 600 && !(hold === 1'b0 && pend === 4'h0); i = i + 1)
      @(posedge clk_sys);
    if (i == 600) cmp_val(16'hDEAD, 16'h0);
    repeat (3) @(posedge clk_sys);
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cmp_val(hold, 1'b0);
    cmp_val(ack, 4'hF);
    cmp_val({eopOe, memOe, ioOe}, 3'h0);
    $display("test reset done");
    lowNib <= 4'hA;
    chipSelectN <= 1'b0;
    repeat (6) @(posedge clk_sys);
    cmp_val(prog, 1'b1);
    cmp_val(regSel, 4'hA);
    cmp_val(aov, 1'b0);
    chipSelectN <= 1'b1;
    repeat (4) @(posedge clk_sys);
    $display("test programming done");
    xferType[5:4] <= `DMASEQ_XFER_READ;
    load(2, 16'h0002);
    run(2, 1'b1);
    cmp_val(nRdFall, 16'd3);
    cmp_val(addrSeen, 16'h12F2);
    cmp_val({nIoW > 0, nWr == 0, nStb > 0, nAck > 0}, 4'hF);
    cmp_val(nEop, 16'd1);
    cmp_val(pend, 4'h0);
    $display("test read done");
    xferType[1:0] <= `DMASEQ_XFER_WRITE;
    slow <= 1'b1;
    load(0, 16'h0000);
    run(0, 1'b0);
    cmp_val({nWait > 0, nWr > 0, nRd == 0, nIoR > 0}, 4'hF);
    cmp_val(nEop, 16'd1);
    slow <= 1'b0;
    $display("test write done");
    xferType[3:2] <= `DMASEQ_XFER_VERIFY;
    load(1, 16'h0000);
    run(1, 1'b0);
    cmp_val(nRd + nWr + nIoR + nIoW, 16'd0);
    cmp_val(nEop, 16'd1);
    $display("test verify done");
    memToMem <= 1'b1;
    channelMask <= 4'hF;
    load(0, 16'h0000);
    load(1, 16'h0000);
    run(0, 1'b1);
    cmp_val({nAck == 0, nRd > 0, nWr > 0}, 3'h7);
    cmp_val(nEop, 16'd1);
    memToMem <= 1'b0;
    channelMask <= 4'h0;
    $display("test memory to memory done");
    xferType[3:2] <= `DMASEQ_XFER_READ;
    extEop <= 1'b1;
    load(1, 16'h0005);
    run(1, 1'b1);
    cmp_val(nRdFall < 6, 1'b1);
    cmp_val(nTc, 16'd1);
    cmp_val(pend, 4'h0);
    $display("test external end done");
    cascadeMode[3] <= 1'b1;
    addrDown[3] <= 1'b1;
    xferType[7:6] <= `DMASEQ_XFER_READ;
    load(3, 16'h0001);
    run(3, 1'b1);
    cmp_val(nRdFall, 16'd2);
    cmp_val(nEop, 16'd0);
    cmp_val(nTc, 16'd1);
    cmp_val(addrSeen, 16'h12EF);
    extEop <= 1'b0;
    cascadeMode <= 4'h0;
    $display("test cascade done");
    ackActiveHigh <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmp_val(ack, 4'h0);
    $display("test polarity done");
    complete_run;
  end
endmodule
`default_nettype wire
